// ### inc/gpio_port_consts.vh
// Offsets, reset values and mode codes for the dual byte port block
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// Register addresses as seen on the register port
`define PORT_A_DATA_ADDR   32'hFFFFF000
`define PORT_B_DATA_ADDR   32'hFFFFF001
`define PORT_A_DIR_ADDR    32'hFFFFF002
`define PORT_STATUS_ADDR   32'hFFFFF003
`define PORT_B_DIR_ADDR    32'hFFFFF004
`define PORT_B_FUNC_ADDR   32'hFFFFF005

// Reset values
`define PORT_A_DATA_RESET  8'h00
`define PORT_B_DATA_RESET  8'h00
`define PORT_A_DIR_RESET   8'h00
`define PORT_B_DIR_RESET   8'h00
`define PORT_B_FUNC_RESET  8'h00
`define READ_IDLE_VALUE    8'h00

// Per-bit mode codes, {function bit, direction bit}
`define MODE_INPUT         2'h0
`define MODE_OUTPUT        2'h1
`define MODE_MUX_AD        2'h2
`define MODE_ADDR_ONLY     2'h3

// Status register field positions
`define STAT_TAKEOVER_BIT  0
`define STAT_WIDE_MUX_BIT  1
`define STAT_WIDE_ADDR_BIT 2
`define STAT_ANY_BUS_BIT   3

`endif

// ### verilog/port_byte_mux.v
// One 8-bit port: per-bit mode decode, pin drivers and read-back selection
`timescale 1ns/10ps
`include "gpio_port_consts.vh"

module port_byte_mux #(
	parameter WIDTH = 8
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] dir,
	input  wire [WIDTH-1:0] func,
	input  wire [WIDTH-1:0] latch,
	input  wire             takeover,
	input  wire             busActive,
	input  wire             addrPhase,
	input  wire             dataDrive,
	input  wire [WIDTH-1:0] muxAddr,
	input  wire [WIDTH-1:0] addrOnly,
	input  wire [WIDTH-1:0] busData,
	input  wire [WIDTH-1:0] pinIn,
	output reg  [WIDTH-1:0] pinOut,
	output reg  [WIDTH-1:0] pinOe,
	output wire [WIDTH-1:0] readVal,
	output wire [WIDTH-1:0] muxBits,
	output wire [WIDTH-1:0] addrBits
);

	// Effective mode of one bit; a bus takeover forces the muxed role
	function [1:0] bitMode;
		input f;
		input d;
		input take;
		begin
			if (take) begin
				bitMode = `MODE_MUX_AD;
			end else begin
				bitMode = {f, d};
			end
		end
	endfunction

	wire [WIDTH-1:0] next_pinOut;
	wire [WIDTH-1:0] next_pinOe;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			wire [1:0] mode;
			wire [1:0] progMode;
			reg        drv;
			reg        val;
			assign mode     = bitMode(func[i], dir[i], takeover);
			assign progMode = bitMode(func[i], dir[i], 1'b0);
			// Pin role per mode; muxed bits float while the bus is idle
			always @* begin
				drv = 1'b0;
				val = latch[i];
				case (mode)
					`MODE_INPUT: begin
						drv = 1'b0;
					end
					`MODE_OUTPUT: begin
						drv = 1'b1;
					end
					`MODE_MUX_AD: begin
						drv = busActive & (addrPhase | dataDrive);
						val = addrPhase ? muxAddr[i] : busData[i];
					end
					`MODE_ADDR_ONLY: begin
						drv = 1'b1;
						val = addrOnly[i];
					end
					default: begin
						drv = 1'b0;
					end
				endcase
			end
			assign next_pinOut[i] = val;
			assign next_pinOe[i]  = drv;
			// Output bits echo the latch, all others the pin level
			assign readVal[i]  = (progMode == `MODE_OUTPUT) ? latch[i] : pinIn[i];
			assign muxBits[i]  = (progMode == `MODE_MUX_AD);
			assign addrBits[i] = (progMode == `MODE_ADDR_ONLY);
		end
	endgenerate

	// Pin drivers registered so nothing glitches onto the board
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pinOut <= {WIDTH{1'b0}};
			pinOe  <= {WIDTH{1'b0}};
		end else begin
			pinOut <= next_pinOut;
			pinOe  <= next_pinOe;
		end
	end

endmodule // port_byte_mux

// ### verilog/dual_byte_port_bus_mux.v
// Two byte-wide general-purpose ports with external bus takeover
//
// Behaviour
// - Port A has eight pins, each one's direction set by its own direction bit.
// - A port A direction bit of 0 makes the pin an input and 1 makes it an output.
// - Reset clears every port A direction bit, so all port A pins start as inputs.
// - During an external access port A carries the low address/data byte with no setup.
// - Port A is taken over only during external accesses and otherwise follows its setting.
// - Port B has eight pins whose role comes from a direction bit and a function bit.
// - Port B {function,direction} 00 is input, 01 output, 10 muxed AD high, 11 address only.
// - Reset clears port B latch, direction and function, so all port B pins are inputs.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "gpio_port_consts.vh"

module dual_byte_port_bus_mux #(
	parameter WIDTH = 8
) (
	input  wire               mclk,
	input  wire               reset_n,
	// Register port
	input  wire [31:0]        regAddr,
	input  wire [WIDTH-1:0]   regWdata,
	input  wire               regWrite,
	input  wire               regRead,
	output reg  [WIDTH-1:0]   regRdata,
	// External bus controller side
	input  wire               extAccess,
	input  wire               addrPhase,
	input  wire               dataDrive,
	input  wire [2*WIDTH-1:0] busAddr,
	input  wire [2*WIDTH-1:0] busWdata,
	output reg  [2*WIDTH-1:0] busRdata,
	// Port A pins
	input  wire [WIDTH-1:0]   portAIn,
	output wire [WIDTH-1:0]   portAOut,
	output wire [WIDTH-1:0]   portAOe,
	// Port B pins
	input  wire [WIDTH-1:0]   portBIn,
	output wire [WIDTH-1:0]   portBOut,
	output wire [WIDTH-1:0]   portBOe
);

	// Software-visible state
	reg  [WIDTH-1:0] portALatch;
	reg  [WIDTH-1:0] portBLatch;
	reg  [WIDTH-1:0] portADir;
	reg  [WIDTH-1:0] portBDir;
	reg  [WIDTH-1:0] portBFunc;

	// Next values of the software-visible state
	reg  [WIDTH-1:0] next_portALatch;
	reg  [WIDTH-1:0] next_portBLatch;
	reg  [WIDTH-1:0] next_portADir;
	reg  [WIDTH-1:0] next_portBDir;
	reg  [WIDTH-1:0] next_portBFunc;

	// Read-back and mode views from the port cells
	wire [WIDTH-1:0] portARead;
	wire [WIDTH-1:0] portBRead;
	wire [WIDTH-1:0] portBMuxBits;
	wire [WIDTH-1:0] portBAddrBits;

	// Bus address and data split into bytes
	wire [WIDTH-1:0] addrLow;
	wire [WIDTH-1:0] addrHigh;
	wire [WIDTH-1:0] dataLow;
	wire [WIDTH-1:0] dataHigh;

	// Decoded strobes
	wire             wrADataHit;
	wire             wrBDataHit;
	wire             wrADirHit;
	wire             wrBDirHit;
	wire             wrBFuncHit;

	// Slots of the one-hot register select; the status slot sits between
	// the two direction registers just as its address does
	localparam SEL_A_DATA = 0;
	localparam SEL_B_DATA = 1;
	localparam SEL_A_DIR  = 2;
	localparam SEL_STATUS = 3;
	localparam SEL_B_DIR  = 4;
	localparam SEL_B_FUNC = 5;
	localparam SEL_COUNT  = 6;

	// Register select, then qualified by each strobe
	wire [SEL_COUNT-1:0] addrSel;
	wire [SEL_COUNT-1:0] wrSel;
	wire [SEL_COUNT-1:0] rdSel;
	wire                 rdCtrlHit;

	// Status view and its fields
	wire             statusAllMux;
	wire             statusAllAddr;
	wire             statusAnyBus;
	reg  [WIDTH-1:0] statusView;

	// Read path
	reg  [WIDTH-1:0] next_regRdata;

	// Bus read capture, one lane per port
	wire             captureNow;
	wire [WIDTH-1:0] captureHigh;
	reg  [WIDTH-1:0] next_busRdataLow;
	reg  [WIDTH-1:0] next_busRdataHigh;

	// Single address comparison, used by every decode below
	function hit;
		input [31:0] addr;
		input [31:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// Full decode to one select line per register; an unmapped address
	// raises no line, so its write is dropped and its read gives zero
	function [SEL_COUNT-1:0] decodeSel;
		input [31:0] addr;
		begin
			decodeSel             = {SEL_COUNT{1'b0}};
			decodeSel[SEL_A_DATA] = hit(addr, `PORT_A_DATA_ADDR);
			decodeSel[SEL_B_DATA] = hit(addr, `PORT_B_DATA_ADDR);
			decodeSel[SEL_A_DIR]  = hit(addr, `PORT_A_DIR_ADDR);
			decodeSel[SEL_STATUS] = hit(addr, `PORT_STATUS_ADDR);
			decodeSel[SEL_B_DIR]  = hit(addr, `PORT_B_DIR_ADDR);
			decodeSel[SEL_B_FUNC] = hit(addr, `PORT_B_FUNC_ADDR);
		end
	endfunction

	// Byte lanes of the external address and write data
	assign addrLow  = busAddr[WIDTH-1:0];
	assign addrHigh = busAddr[2*WIDTH-1:WIDTH];
	assign dataLow  = busWdata[WIDTH-1:0];
	assign dataHigh = busWdata[2*WIDTH-1:WIDTH];

	// One decode shared by the write and read paths
	assign addrSel   = decodeSel(regAddr);
	assign wrSel     = addrSel & {SEL_COUNT{regWrite}};
	assign rdSel     = addrSel & {SEL_COUNT{regRead}};
	assign rdCtrlHit = rdSel[SEL_A_DIR] | rdSel[SEL_B_DIR] | rdSel[SEL_B_FUNC];

	// Write decode; a write never needs more than one cycle
	assign wrADataHit = wrSel[SEL_A_DATA];
	assign wrBDataHit = wrSel[SEL_B_DATA];
	assign wrADirHit  = wrSel[SEL_A_DIR];
	assign wrBDirHit  = wrSel[SEL_B_DIR];
	assign wrBFuncHit = wrSel[SEL_B_FUNC];

	// Next register values; each holds unless its own strobe hits, so a
	// write to one register can never disturb another
	always @* begin
		next_portALatch = portALatch;
		next_portBLatch = portBLatch;
		next_portADir   = portADir;
		next_portBDir   = portBDir;
		next_portBFunc  = portBFunc;
		if (wrADataHit) begin
			next_portALatch = regWdata;
		end
		if (wrBDataHit) begin
			next_portBLatch = regWdata;
		end
		if (wrADirHit) begin
			next_portADir = regWdata;
		end
		if (wrBDirHit) begin
			next_portBDir = regWdata;
		end
		if (wrBFuncHit) begin
			next_portBFunc = regWdata;
		end
	end

	// Port A output latch; writes land here even while the bus owns the pins
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			portALatch <= `PORT_A_DATA_RESET;
		end else begin
			portALatch <= next_portALatch;
		end
	end

	// Port B output latch
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			portBLatch <= `PORT_B_DATA_RESET;
		end else begin
			portBLatch <= next_portBLatch;
		end
	end

	// Port A direction, one bit per pin, all inputs out of reset
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			portADir <= `PORT_A_DIR_RESET;
		end else begin
			portADir <= next_portADir;
		end
	end

	// Port B direction
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			portBDir <= `PORT_B_DIR_RESET;
		end else begin
			portBDir <= next_portBDir;
		end
	end

	// Port B function; only software changes it, the bus never does
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			portBFunc <= `PORT_B_FUNC_RESET;
		end else begin
			portBFunc <= next_portBFunc;
		end
	end

	// Port A cell: the takeover line forces every bit onto the low AD byte
	// only while an external access is under way, whatever the direction bits say
	port_byte_mux #(
		.WIDTH     (WIDTH)
	) u_portA (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.dir       (portADir),
		.func      ({WIDTH{1'b0}}),
		.latch     (portALatch),
		.takeover  (extAccess),
		.busActive (extAccess),
		.addrPhase (addrPhase),
		.dataDrive (dataDrive),
		.muxAddr   (addrLow),
		.addrOnly  (addrLow),
		.busData   (dataLow),
		.pinIn     (portAIn),
		.pinOut    (portAOut),
		.pinOe     (portAOe),
		.readVal   (portARead),
		.muxBits   (),
		.addrBits  ()
	);

	// Port B cell: no takeover, roles come only from function and direction
	port_byte_mux #(
		.WIDTH     (WIDTH)
	) u_portB (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.dir       (portBDir),
		.func      (portBFunc),
		.latch     (portBLatch),
		.takeover  (1'b0),
		.busActive (extAccess),
		.addrPhase (addrPhase),
		.dataDrive (dataDrive),
		.muxAddr   (addrHigh),
		.addrOnly  (addrHigh),
		.busData   (dataHigh),
		.pinIn     (portBIn),
		.pinOut    (portBOut),
		.pinOe     (portBOe),
		.readVal   (portBRead),
		.muxBits   (portBMuxBits),
		.addrBits  (portBAddrBits)
	);

	// Status fields: whole-port bus modes and any bus mode at all
	assign statusAllMux  = &portBMuxBits;
	assign statusAllAddr = &portBAddrBits;
	assign statusAnyBus  = (|portBMuxBits) | (|portBAddrBits);

	// Status: lets software check the wide bus setup before using it;
	// unused positions read as zero
	always @* begin
		statusView                      = {WIDTH{1'b0}};
		statusView[`STAT_TAKEOVER_BIT]  = extAccess;
		statusView[`STAT_WIDE_MUX_BIT]  = statusAllMux;
		statusView[`STAT_WIDE_ADDR_BIT] = statusAllAddr;
		statusView[`STAT_ANY_BUS_BIT]   = statusAnyBus;
	end

	// Read multiplexer; control registers read as zero since they are write-only
	always @* begin
		next_regRdata = `READ_IDLE_VALUE;
		if (rdSel[SEL_A_DATA]) begin
			next_regRdata = portARead;
		end else if (rdSel[SEL_B_DATA]) begin
			next_regRdata = portBRead;
		end else if (rdSel[SEL_STATUS]) begin
			next_regRdata = statusView;
		end else if (rdCtrlHit) begin
			next_regRdata = `READ_IDLE_VALUE;
		end else begin
			next_regRdata = `READ_IDLE_VALUE;
		end
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			regRdata <= `READ_IDLE_VALUE;
		end else begin
			regRdata <= next_regRdata;
		end
	end

	// Bus read data is caught in the data phase when nobody drives the pins;
	// the high byte only counts where port B carries muxed AD
	assign captureNow  = extAccess & ~addrPhase & ~dataDrive;
	assign captureHigh = portBIn & portBMuxBits;

	// Low lane follows port A on every capture
	always @* begin
		next_busRdataLow = busRdata[WIDTH-1:0];
		if (captureNow) begin
			next_busRdataLow = portAIn;
		end
	end

	// High lane keeps only the bits that port B carries as muxed AD
	always @* begin
		next_busRdataHigh = busRdata[2*WIDTH-1:WIDTH];
		if (captureNow) begin
			next_busRdataHigh = captureHigh;
		end
	end

	// Held until the next capture so the controller may take it late
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busRdata <= {(2*WIDTH){1'b0}};
		end else begin
			busRdata <= {next_busRdataHigh, next_busRdataLow};
		end
	end

endmodule // dual_byte_port_bus_mux

// ### verif/dual_byte_port_bus_mux_props.sv
// Port-level assertions for the dual byte port block
`timescale 1ns/10ps
`include "gpio_port_consts.vh"
module dual_byte_port_bus_mux_props #(
	parameter WIDTH = 8
) (
	input wire               mclk,
	input wire               reset_n,
	input wire [31:0]        regAddr,
	input wire [WIDTH-1:0]   regWdata,
	input wire               regWrite,
	input wire               regRead,
	input wire [WIDTH-1:0]   regRdata,
	input wire               extAccess,
	input wire               addrPhase,
	input wire               dataDrive,
	input wire [2*WIDTH-1:0] busAddr,
	input wire [2*WIDTH-1:0] busWdata,
	input wire [2*WIDTH-1:0] busRdata,
	input wire [WIDTH-1:0]   portAIn,
	input wire [WIDTH-1:0]   portAOut,
	input wire [WIDTH-1:0]   portAOe,
	input wire [WIDTH-1:0]   portBIn,
	input wire [WIDTH-1:0]   portBOut,
	input wire [WIDTH-1:0]   portBOe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Takeover drives port A in address and write phases, releases it while reading
	chk_a_takeover_oe: assert property (extAccess |=>
		portAOe == {WIDTH{$past(addrPhase) | $past(dataDrive)}}) else $error("port A enable bad");
	chk_a_addr_out: assert property (extAccess && addrPhase |=>
		portAOut == $past(busAddr[WIDTH-1:0])) else $error("port A address bad");
	chk_a_wdata_out: assert property (extAccess && !addrPhase && dataDrive |=>
		portAOut == $past(busWdata[WIDTH-1:0])) else $error("port A write data bad");
	chk_bus_capture: assert property (extAccess && !addrPhase && !dataDrive |=>
		busRdata[WIDTH-1:0] == $past(portAIn)) else $error("bus capture bad");
	// Outside accesses and without writes no enable may move on its own
	chk_enables_settled: assert property ((!extAccess && !regWrite)[*2] |=>
		$stable(portAOe) && $stable(portBOe)) else $error("enable moved by itself");
	chk_reset_inputs: assert property ($rose(reset_n) && !regWrite && !extAccess |=>
		portAOe == 0 && portBOe == 0) else $error("pins not inputs after reset");
	chk_rdata_idle: assert property (!regRead |=> regRdata == 0)
		else $error("read data outside read slot");
	chk_ctrl_read_zero: assert property (regRead && (regAddr == `PORT_A_DIR_ADDR ||
		regAddr == `PORT_B_DIR_ADDR || regAddr == `PORT_B_FUNC_ADDR) |=> regRdata == 0)
		else $error("control register read back");
	cover property (extAccess && addrPhase);
	cover property (extAccess && dataDrive);
	cover property (regRead ##1 regRdata != 0);
endmodule // dual_byte_port_bus_mux_props

bind dual_byte_port_bus_mux dual_byte_port_bus_mux_props #(.WIDTH(WIDTH)) i_props (.*);

// ### verif/ext_mem_model.sv
// Behavioural external memory on the multiplexed address/data bus
`timescale 1ns/10ps
module ext_mem_model (
	input  wire        mclk,
	input  wire        addrLatch,
	input  wire        writeEn,
	input  wire [15:0] padIn,
	output wire [15:0] dataOut
);
	reg [15:0] mem [0:255];
	reg [7:0]  addr;
	// Last edge of each phase wins, since the pins lag the bus phase by one cycle
	always @(posedge mclk) begin
		if (addrLatch)
			addr <= padIn[7:0];
		if (writeEn)
			mem[addr] <= padIn;
	end
	// Read data; the bench gates it onto the wires only in the read phase
	assign dataOut = mem[addr];
endmodule // ext_mem_model

// ### verif/dual_byte_port_bus_mux_tb.sv
// Self-checking bench for the dual byte port block
`timescale 1ns/10ps
`include "gpio_port_consts.vh"
module dual_byte_port_bus_mux_tb;
	parameter WIDTH = 8;
	reg         mclk = 0;
	reg         reset_n = 0;
	reg  [31:0] regAddr = 0;
	reg  [7:0]  regWdata = 0;
	reg         regWrite = 0;
	reg         regRead = 0;
	wire [7:0]  regRdata;
	reg         extAccess = 0;
	reg         addrPhase = 0;
	reg         dataDrive = 0;
	reg  [15:0] busAddr = 0;
	reg  [15:0] busWdata = 0;
	wire [15:0] busRdata;
	wire [7:0]  portAIn, portAOut, portAOe, portBIn, portBOut, portBOe;
	wire [15:0] memData;
	wire        memRd;
	reg  [7:0]  padA = 8'hA0;
	reg  [7:0]  padB = 8'h5A;
	integer     nMismatch = 0;
	integer     numChecks = 0;
	// Wire level: the block wins, then memory in its read phase, then board pads
	assign memRd = extAccess & ~addrPhase & ~dataDrive;
	assign portAIn = (portAOe & portAOut) | (~portAOe & (memRd ? memData[7:0] : padA));
	assign portBIn = (portBOe & portBOut) | (~portBOe & (memRd ? memData[15:8] : padB));
	always #20 mclk = ~mclk;
	dual_byte_port_bus_mux #(.WIDTH(WIDTH)) i_dual_byte_port_bus_mux (.*);
	ext_mem_model i_ext_mem_model (.mclk(mclk), .addrLatch(extAccess & addrPhase),
		.writeEn(extAccess & dataDrive), .padIn({portBIn, portAIn}), .dataOut(memData));
	task check(input [7:0] got, input [7:0] exp);
	begin
		numChecks = numChecks + 1;
		if (got !== exp) begin
			nMismatch = nMismatch + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [31:0] a, input [7:0] d);
	begin
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		@(posedge mclk);
		#1;
	end
	endtask
	task rd(input [31:0] a, input [7:0] exp);
	begin
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		check(regRdata, exp);
		@(posedge mclk);
		#1;
	end
	endtask
	// Two cycles per phase, since the pins follow the bus phase one cycle late
	task ext(input w, input [15:0] a, input [15:0] d);
	begin
		extAccess <= 1'b1;
		addrPhase <= 1'b1;
		busAddr <= a;
		busWdata <= d;
		repeat (2) @(posedge mclk);
		#1;
		check(portAOe, 8'hFF);
		check(portAOut, a[7:0]);
		check(portBOut & 8'h30, a[15:8] & 8'h30);
		addrPhase <= 1'b0;
		dataDrive <= w;
		repeat (2) @(posedge mclk);
		#1;
		check(portAOe, w ? 8'hFF : 8'h00);
		extAccess <= 1'b0;
		dataDrive <= 1'b0;
		@(posedge mclk);
		#1;
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		#1;
		check(portAOe, 8'h00);
		check(portBOe, 8'h00);
		rd(`PORT_A_DATA_ADDR, 8'hA0);
		rd(`PORT_B_DATA_ADDR, 8'h5A);
		wr(`PORT_A_DIR_ADDR, 8'h0F);
		check(portAOe, 8'h0F);
		rd(`PORT_A_DATA_ADDR, 8'hA0);
		wr(`PORT_A_DATA_ADDR, 8'h55);
		check(portAOut & 8'h0F, 8'h05);
		rd(`PORT_A_DATA_ADDR, 8'hA5);
		rd(`PORT_A_DIR_ADDR, 8'h00);
		rd(32'hFFFFF006, 8'h00);
		// Port B gets its bus roles from software before any wide access
		busAddr <= 16'h8000;
		wr(`PORT_B_DATA_ADDR, 8'hFF);
		wr(`PORT_B_DIR_ADDR, 8'hCC);
		wr(`PORT_B_FUNC_ADDR, 8'hF0);
		check(portBOe, 8'hCC);
		check(portBOut & 8'hCC, 8'h8C);
		rd(`PORT_B_DATA_ADDR, 8'h9E);
		rd(`PORT_B_FUNC_ADDR, 8'h00);
		rd(`PORT_STATUS_ADDR, 8'h08);
		ext(1'b1, 16'hAB3C, 16'hBEEF);
		check(portAOe, 8'h0F);
		check(portAOut & 8'h0F, 8'h05);
		ext(1'b0, 16'hAB3C, 16'h0000);
		check(busRdata[7:0], 8'hEF);
		check(busRdata[15:8], 8'h30);
		end_sim;
	end
endmodule // dual_byte_port_bus_mux_tb
